// *** xadle_pkg.sv ***
// constants for the xor and direction-load execute block
// assumes a 14-bit instruction word and an 8-bit data path
package xadle_pkg;
   localparam logic [13:0] XOR_IMM_MASK    = 14'h3F00;
   localparam logic [13:0] XOR_IMM_MATCH   = 14'h3A00;
   localparam logic [13:0] XOR_FILE_MASK   = 14'h3F00;
   localparam logic [13:0] XOR_FILE_MATCH  = 14'h0600;
   localparam logic [13:0] DIR_LOAD_MASK   = 14'h3FF8;
   localparam logic [13:0] DIR_LOAD_MATCH  = 14'h0060;
   localparam int          DEST_BIT        = 7;
   localparam logic [2:0]  DIR_SEL_LOW     = 3'h5;
   localparam logic [2:0]  DIR_SEL_HIGH    = 3'h7;
   // file addresses at which the direction registers are also reachable
   localparam logic [6:0]  DIR_FILE_ADDR_A = 7'h05;
   localparam logic [6:0]  DIR_FILE_ADDR_B = 7'h06;
   localparam logic [6:0]  DIR_FILE_ADDR_C = 7'h07;
   localparam logic [7:0]  ACC_RESET       = 8'h00;
   localparam logic [7:0]  DIR_RESET       = 8'hFF;
   localparam logic        ZERO_RESET      = 1'h0;
endpackage

// *** xadle_core.sv ***
// execute stage for immediate xor, file xor and direction load
// assumes one instruction presented per enabled cycle; file data read combinationally
`timescale 1ns/100ps
module xadle_core
   import xadle_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        clkEn,
   input  wire logic        instrValid,
   input  wire logic [13:0] instrWord,
   input  wire logic [7:0]  fileRdData,
   output logic      [6:0]  fileAddr,
   output logic      [7:0]  fileWrData,
   output logic             fileWrEn,
   output logic      [7:0]  accumulator,
   output logic             zeroFlag,
   output logic      [7:0]  portDirA,
   output logic      [7:0]  portDirB,
   output logic      [7:0]  portDirC,
   output logic      [7:0]  dirRdData
);
   logic [7:0] next_accumulator;
   logic       next_zeroFlag;
   logic [7:0] next_portDirA;
   logic [7:0] next_portDirB;
   logic [7:0] next_portDirC;
   logic [6:0] next_fileAddr;
   logic [7:0] next_fileWrData;
   logic       next_fileWrEn;
   logic [7:0] next_dirRdData;
   logic       isImm;
   logic       isFile;
   logic       isDir;
   logic [7:0] fileOperand;
   logic [7:0] result;
   logic [6:0] addrField;

   assign addrField = instrWord[6:0];

   always_comb
   begin
      isImm  = instrValid && ((instrWord & XOR_IMM_MASK) == XOR_IMM_MATCH);
      isFile = instrValid && ((instrWord & XOR_FILE_MASK) == XOR_FILE_MATCH);
      isDir  = instrValid && ((instrWord & DIR_LOAD_MASK) == DIR_LOAD_MATCH)
               && (instrWord[2:0] >= DIR_SEL_LOW) && (instrWord[2:0] <= DIR_SEL_HIGH);
      // direction registers answer their file addresses instead of the data file
      if (addrField == DIR_FILE_ADDR_A)
         fileOperand = portDirA;
      else if (addrField == DIR_FILE_ADDR_B)
         fileOperand = portDirB;
      else if (addrField == DIR_FILE_ADDR_C)
         fileOperand = portDirC;
      else
         fileOperand = fileRdData;
      result = 8'h00;
      next_accumulator = accumulator;
      next_zeroFlag    = zeroFlag;
      next_portDirA    = portDirA;
      next_portDirB    = portDirB;
      next_portDirC    = portDirC;
      next_fileAddr    = addrField;
      next_fileWrData  = fileWrData;
      next_fileWrEn    = 1'b0;
      next_dirRdData   = fileOperand;
      if (isImm)
      begin
         result           = accumulator ^ instrWord[7:0];
         next_accumulator = result;
         next_zeroFlag    = (result == 8'h00);
      end
      else if (isFile)
      begin
         result        = accumulator ^ fileOperand;
         next_zeroFlag = (result == 8'h00);
         if (!instrWord[DEST_BIT])
            next_accumulator = result;
         else if (addrField == DIR_FILE_ADDR_A)
            next_portDirA = result;
         else if (addrField == DIR_FILE_ADDR_B)
            next_portDirB = result;
         else if (addrField == DIR_FILE_ADDR_C)
            next_portDirC = result;
         else
         begin
            next_fileWrEn   = 1'b1;
            next_fileWrData = result;
         end
      end
      else if (isDir)
      begin
         if (instrWord[2:0] == DIR_SEL_LOW)
            next_portDirA = accumulator;
         else if (instrWord[2:0] == DIR_SEL_HIGH)
            next_portDirC = accumulator;
         else
            next_portDirB = accumulator;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         accumulator <= ACC_RESET;
         zeroFlag    <= ZERO_RESET;
         portDirA    <= DIR_RESET;
         portDirB    <= DIR_RESET;
         portDirC    <= DIR_RESET;
         fileAddr    <= 7'h00;
         fileWrData  <= 8'h00;
         fileWrEn    <= 1'b0;
         dirRdData   <= 8'h00;
      end
      else if (clkEn)
      begin
         accumulator <= next_accumulator;
         zeroFlag    <= next_zeroFlag;
         portDirA    <= next_portDirA;
         portDirB    <= next_portDirB;
         portDirC    <= next_portDirC;
         fileAddr    <= next_fileAddr;
         fileWrData  <= next_fileWrData;
         fileWrEn    <= next_fileWrEn;
         dirRdData   <= next_dirRdData;
      end
   end

   // helper decodes sampled for checks
   logic       pImm;
   logic       pFile;
   logic       pDir;
   // reset is sampled here too: disable iff alone reads it late at the release edge
   assign pImm  = resetn && clkEn && isImm;
   assign pFile = resetn && clkEn && isFile;
   assign pDir  = resetn && clkEn && isDir;

   sequence immIssued;
      pImm;
   endsequence

   sequence fileIssued;
      pFile;
   endsequence

   sequence dirLowThenEnabled;
      pDir && instrWord[2:0] == DIR_SEL_LOW ##1 clkEn;
   endsequence

   imm_xor_acc_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      immIssued |=> accumulator == ($past(accumulator) ^ $past(instrWord[7:0])))
      else $error("immediate xor result wrong");
   imm_zero_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pImm |=> zeroFlag == (accumulator == 8'h00))
      else $error("immediate xor zero flag wrong");
   imm_dirs_kept_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pImm |=> $stable(portDirA) && $stable(portDirB) && $stable(portDirC) && !fileWrEn)
      else $error("immediate xor touched other state");
   file_zero_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      fileIssued |=> zeroFlag == (($past(accumulator) ^ $past(fileOperand)) == 8'h00))
      else $error("file xor zero flag wrong");
   dest_acc_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pFile && !instrWord[DEST_BIT] |=> accumulator == ($past(accumulator) ^ $past(fileOperand)) && !fileWrEn)
      else $error("file xor to acc wrong");
   dest_file_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pFile && instrWord[DEST_BIT] && (addrField < DIR_FILE_ADDR_A || addrField > DIR_FILE_ADDR_C)
      |=> fileWrEn && fileWrData == ($past(accumulator) ^ $past(fileRdData)) && fileAddr == $past(addrField)
         && $stable(accumulator))
      else $error("file xor write back wrong");
   dir_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pDir && instrWord[2:0] == DIR_SEL_HIGH |=> portDirC == $past(accumulator) && $stable(zeroFlag))
      else $error("direction load wrong");
   dir_file_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pFile && instrWord[DEST_BIT] && addrField == DIR_FILE_ADDR_A
      |=> portDirA == ($past(accumulator) ^ $past(portDirA)) && !fileWrEn)
      else $error("direction register file write wrong");
   one_cycle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      dirLowThenEnabled |-> portDirA == $past(accumulator))
      else $error("instruction took more than one cycle");
   dir_load_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pDir && instrWord[2:0] == DIR_SEL_LOW |=> portDirA == $past(accumulator) && $stable(zeroFlag))
      else $error("direction load low select wrong");
   dir_load_mid_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pDir && instrWord[2:0] > DIR_SEL_LOW && instrWord[2:0] < DIR_SEL_HIGH
      |=> portDirB == $past(accumulator) && $stable(zeroFlag) && !fileWrEn)
      else $error("direction load middle select wrong");
   dir_sel_refused_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      resetn && clkEn && instrValid && (instrWord & DIR_LOAD_MASK) == DIR_LOAD_MATCH && instrWord[2:0] < DIR_SEL_LOW
      |=> $stable(portDirA) && $stable(portDirB) && $stable(portDirC) && $stable(accumulator))
      else $error("direction load below select range acted");
   dir_file_b_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pFile && instrWord[DEST_BIT] && addrField == DIR_FILE_ADDR_B
      |=> portDirB == ($past(accumulator) ^ $past(portDirB)) && !fileWrEn)
      else $error("second direction register file write wrong");
   dir_file_c_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      pFile && instrWord[DEST_BIT] && addrField == DIR_FILE_ADDR_C
      |=> portDirC == ($past(accumulator) ^ $past(portDirC)) && !fileWrEn)
      else $error("third direction register file write wrong");
   dir_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      resetn && clkEn && addrField == DIR_FILE_ADDR_C |=> dirRdData == $past(portDirC))
      else $error("direction register file read wrong");
   wr_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      resetn && clkEn && !isFile |=> !fileWrEn)
      else $error("file write without file xor");
   freeze_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      resetn && !clkEn |=> $stable(accumulator) && $stable(zeroFlag) && $stable(portDirA)
         && $stable(portDirB) && $stable(portDirC) && $stable(fileWrEn) && $stable(fileAddr)
         && $stable(fileWrData) && $stable(dirRdData))
      else $error("state moved while clock enable low");
endmodule

// *** xor_and_direction_load_execute_tb_top.sv ***
// self-checking bench for the xor and direction-load execute stage
// assumes xadle_pkg and xadle_core are compiled first
`timescale 1ns/100ps
module xor_and_direction_load_execute_tb_top;
   import xadle_pkg::*;
   typedef struct {int due; logic [7:0] acc, dA, dB, dC, wd, rd; logic z, we; logic [6:0] wa;} xadle_note_s;
   logic        ref_clk = 0;
   logic        resetn = 0;
   logic        clkEn = 1;
   logic        instrValid = 0;
   logic [13:0] instrWord = 14'h0000;
   logic [7:0]  fileRdData = 8'h00;
   logic [6:0]  fileAddr;
   logic [7:0]  fileWrData, accumulator, portDirA, portDirB, portDirC, dirRdData;
   logic        fileWrEn, zeroFlag;
   logic [7:0]  mAcc, mDir [0:2];
   logic        mZ, mWe;
   logic [7:0]  mWd, mRd;
   logic [6:0]  mWa;
   logic [31:0] seed = 32'h2910;
   int          cyc = 0, bad_count = 0, comparisons = 0;
   xadle_note_s q [$], got;
   xadle_core dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .instrValid(instrValid),
      .instrWord(instrWord), .fileRdData(fileRdData), .fileAddr(fileAddr), .fileWrData(fileWrData),
      .fileWrEn(fileWrEn), .accumulator(accumulator), .zeroFlag(zeroFlag), .portDirA(portDirA),
      .portDirB(portDirB), .portDirC(portDirC), .dirRdData(dirRdData));
   initial
   begin
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // drive one cycle and note what it must leave behind one edge later
   task automatic issue(input logic rn, en, v, input logic [13:0] w, input logic [7:0] rd);
      xadle_note_s n;
      logic [7:0] op, res;
      logic isDir;
      @(posedge ref_clk);
      resetn <= rn;
      clkEn <= en;
      instrValid <= v;
      instrWord <= w;
      fileRdData <= rd;
      isDir = w[6:0] >= DIR_FILE_ADDR_A && w[6:0] <= DIR_FILE_ADDR_C;
      op = isDir ? mDir[w[1:0] - 1] : rd;
      res = mAcc ^ op;
      n = '{default: 0};
      n.due = cyc + 2;
      // a frozen cycle keeps every output, the write pulse included
      if (!rn)
      begin
         mAcc = ACC_RESET;
         mZ = ZERO_RESET;
         mDir = '{DIR_RESET, DIR_RESET, DIR_RESET};
         mWe = 1'b0;
         mWd = 8'h00;
         mWa = 7'h00;
         mRd = 8'h00;
      end
      else if (en)
      begin
         mWe = 1'b0;
         mWa = w[6:0];
         mRd = op;
         if (v && (w & XOR_IMM_MASK) == XOR_IMM_MATCH)
         begin
            mAcc ^= w[7:0];
            mZ = mAcc == 8'h00;
         end
         else if (v && (w & XOR_FILE_MASK) == XOR_FILE_MATCH)
         begin
            mZ = res == 8'h00;
            if (!w[DEST_BIT]) mAcc = res;
            else if (isDir) mDir[w[1:0] - 1] = res;
            else
            begin
               mWe = 1'b1;
               mWd = res;
            end
         end
         else if (v && (w & DIR_LOAD_MASK) == DIR_LOAD_MATCH && w[2:0] >= DIR_SEL_LOW)
            mDir[w[1:0] - 1] = mAcc;
      end
      n.we = mWe;
      n.wd = mWd;
      n.wa = mWa;
      n.rd = mRd;
      n.acc = mAcc;
      n.z = mZ;
      n.dA = mDir[0];
      n.dB = mDir[1];
      n.dC = mDir[2];
      q.push_back(n);
   endtask
   always @(negedge ref_clk)
      while (q.size() > 0 && q[0].due <= cyc)
      begin
         got = q.pop_front();
         cmp("accumulator", got.acc, accumulator);
         cmp("zeroFlag", {7'h00, got.z}, {7'h00, zeroFlag});
         cmp("portDirA", got.dA, portDirA);
         cmp("portDirB", got.dB, portDirB);
         cmp("portDirC", got.dC, portDirC);
         cmp("fileWrEn", {7'h00, got.we}, {7'h00, fileWrEn});
         cmp("fileWrData", got.wd, fileWrData);
         cmp("fileAddr", {1'b0, got.wa}, {1'b0, fileAddr});
         cmp("dirRdData", got.rd, dirRdData);
      end
   task automatic final_report;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #(40 * 3000);
      bad_count++;
      final_report();
   end
   initial
   begin
      logic [13:0] w;
      logic [6:0] f;
      repeat (6) issue(0, 1, 1, 14'h3AFF, 8'h55);
      issue(1, 1, 1, 14'h3AB5, 8'h00);
      issue(1, 1, 1, 14'h3AAF, 8'h00);
      issue(1, 1, 1, 14'h06A0, 8'h3C);
      issue(1, 1, 1, 14'h0065, 8'h00);
      issue(1, 1, 1, 14'h0086, 8'hA5);
      $display("walk test done");
      for (int i = 0; i < 600; i++)
      begin
         seed = xs(seed);
         f = seed[4] ? {5'h01, seed[6:5]} : seed[22:16];
         case (seed[2:0])
            0, 1: w = {6'h3A, seed[3] ? mAcc : seed[15:8]};
            2, 3: w = {6'h06, seed[7], f};
            4: w = {11'h00C, seed[10:8]};
            default: w = {6'h0E, seed[7:0]};
         endcase
         // enable and valid drop on any opcode, not only on refused ones
         issue(i != 300, seed[12:11] != 2'h0, seed[14:13] != 2'h0, w, seed[31:24]);
      end
      repeat (3) @(posedge ref_clk);
      cmp("pendingNotes", 8'h00, 8'(q.size()));
      $display("random test done");
      final_report();
   end
endmodule
